// File: pkg/ulm_pkg.sv
// Package for the user LED mapping register bank.
// Assumes a byte-wide register port driven by the serial interface engine.
package ulm_pkg;
   localparam logic [7:0] ULM_GREEN_MAP_OFS = 8'h18;
   localparam logic [7:0] ULM_BLUE_MAP_OFS  = 8'h19;
   localparam logic [7:0] ULM_MAP_RESET     = 8'h00;
   localparam logic [7:0] ULM_READ_UNMAPPED = 8'h00;
   // Indicator bit positions inside each mapping byte
   localparam int ULM_BIT_BACKUP_ACTIVE  = 0;
   localparam int ULM_BIT_CELL_POWER     = 1;
   localparam int ULM_BIT_CHARGING       = 2;
   localparam int ULM_BIT_INFO_TEMP      = 3;
   localparam int ULM_BIT_FAN            = 4;
   localparam int ULM_BIT_SWITCH_OUTPUT  = 5;
   localparam int ULM_BIT_HOST_SUPPLY    = 6;
   localparam int ULM_BIT_OUTSIDE_INPUT  = 7;
   // User LED indices
   localparam int ULM_LED_GREEN = 0;
   localparam int ULM_LED_BLUE  = 1;
   localparam int ULM_NUM_LEDS  = 2;
   // Buttons: the low three are the user buttons
   localparam int ULM_NUM_BUTTONS = 6;
   localparam int ULM_NUM_USER_BUTTONS = 3;
   localparam int ULM_SYNC_STAGES = 2;

   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ulm_reg_req_t;

   typedef struct packed
   {
      logic [ULM_NUM_LEDS-1:0] wr;
      logic [ULM_NUM_LEDS-1:0] on;
   } ulm_led_cmd_t;
endpackage

// File: test/test_ulm_led_map.sv
// Self-checking bench for the user LED mapping register bank.
// Assumes the host model owns the register port; the bench drives the rest.
`timescale 1ns/100ps
module test_ulm_led_map;
   import ulm_pkg::*;
   logic         sys_clk = 1'b0;
   logic         resetn = 1'b0;
   ulm_reg_req_t reg_req;
   logic [7:0]   reg_rdata;
   logic         reg_rvalid;
   ulm_led_cmd_t led_cmd = '0;
   logic [7:0]   sys_indicators = 8'h00;
   logic         status_update = 1'b0;
   logic [5:0]   button_pin = 6'h00;
   logic [1:0]   user_led_on;
   logic [2:0]   user_button_state;
   logic [5:3]   sys_button_state;
   int           num_errors = 0;
   int           check_count = 0;
   logic [7:0]   rd_val;
   logic         rd_ok;
   // Green map, blue map, indicators, expected LEDs {blue,green}
   logic [7:0]   rows [6][4] = '{'{8'h01, 8'h00, 8'h01, 8'h01},
      '{8'h80, 8'h02, 8'h82, 8'h03}, '{8'h0C, 8'h30, 8'h08, 8'h01},
      '{8'h00, 8'h40, 8'hFF, 8'h03}, '{8'h04, 8'h00, 8'hFB, 8'h02},
      '{8'hFF, 8'hFF, 8'h00, 8'h00}};

   always #10 sys_clk = ~sys_clk;

   ulm_led_map dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .led_cmd(led_cmd),
      .sys_indicators(sys_indicators), .status_update(status_update),
      .button_pin(button_pin), .user_led_on(user_led_on),
      .user_button_state(user_button_state), .sys_button_state(sys_button_state));
   ulm_host_model host_u (.sys_clk(sys_clk), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      host_u.rd(a, rd_val, rd_ok);
      chk(rd_val, exp);
      chk({7'h00, rd_ok}, 8'h01);
   endtask
   // One pulse of host command and/or status refresh
   task automatic evt(input logic [1:0] cw, input logic [1:0] con, input logic su,
                      input logic [7:0] ind);
      @(negedge sys_clk);
      led_cmd = '{cw, con};
      status_update = su;
      sys_indicators = ind;
      @(negedge sys_clk);
      led_cmd = '0;
      status_update = 1'b0;
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(negedge sys_clk);
      chk({6'h00, user_led_on}, 8'h00);
      resetn = 1'b1;
      rdchk(ULM_GREEN_MAP_OFS, ULM_MAP_RESET);
      rdchk(ULM_BLUE_MAP_OFS, ULM_MAP_RESET);
      $display("test reset done");
      foreach (rows[i])
      begin
         host_u.wr(ULM_GREEN_MAP_OFS, rows[i][0]);
         host_u.wr(ULM_BLUE_MAP_OFS, rows[i][1]);
         rdchk(ULM_GREEN_MAP_OFS, rows[i][0]);
         rdchk(ULM_BLUE_MAP_OFS, rows[i][1]);
         evt(2'b00, 2'b00, 1'b1, rows[i][2]);
         chk({6'h00, user_led_on}, rows[i][3]);
      end
      $display("test table done");
      host_u.wr(8'h1A, 8'h55);
      rdchk(8'h1A, ULM_READ_UNMAPPED);
      rdchk(ULM_GREEN_MAP_OFS, 8'hFF);
      host_u.wrrd(ULM_GREEN_MAP_OFS, 8'h5A, rd_val, rd_ok);
      chk(rd_val, 8'h5A);
      chk({7'h00, rd_ok}, 8'h01);
      host_u.wr(ULM_GREEN_MAP_OFS, 8'hFF);
      evt(2'b11, 2'b11, 1'b0, 8'h00);
      chk({6'h00, user_led_on}, 8'h03);
      evt(2'b00, 2'b00, 1'b1, 8'h00);
      chk({6'h00, user_led_on}, 8'h00);
      // Command and refresh together: refresh wins
      evt(2'b11, 2'b00, 1'b1, 8'h01);
      chk({6'h00, user_led_on}, 8'h03);
      host_u.wr(ULM_BLUE_MAP_OFS, 8'h00);
      evt(2'b10, 2'b10, 1'b0, 8'h00);
      evt(2'b00, 2'b00, 1'b1, 8'h00);
      chk({6'h00, user_led_on}, 8'h02);
      $display("test override done");
      button_pin = 6'h2A;
      repeat (4) @(negedge sys_clk);
      chk({5'h00, user_button_state}, 8'h02);
      chk({5'h00, sys_button_state}, 8'h05);
      $display("test buttons done");
      // Reset in mid-run must clear the LEDs and both mapping bytes
      resetn = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({6'h00, user_led_on}, 8'h00);
      resetn = 1'b1;
      rdchk(ULM_GREEN_MAP_OFS, ULM_MAP_RESET);
      rdchk(ULM_BLUE_MAP_OFS, ULM_MAP_RESET);
      $display("test mid reset done");
      summarize();
   end
endmodule

// File: test/ulm_host_model.sv
// Host model: register writes and reads on the byte port.
// Assumes the bench calls its tasks; drives at the falling edge.
`timescale 1ns/100ps
module ulm_host_model
   import ulm_pkg::*;
(
   input  wire logic       sys_clk,
   output ulm_reg_req_t    reg_req,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial reg_req = '0;
   // Idle fields show inverted values so nothing leans on stale ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_req = '{1'b1, 1'b0, a, d};
      @(negedge sys_clk);
      reg_req = '{1'b0, 1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge sys_clk);
      reg_req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge sys_clk);
      ok = reg_rvalid;
      d = reg_rdata;
      reg_req = '{1'b0, 1'b0, ~a, 8'hFF};
   endtask
   // Write, then read the same offset at the very next edge, as the engine may
   task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
                       output logic ok);
      @(negedge sys_clk);
      reg_req = '{1'b1, 1'b0, a, d};
      @(negedge sys_clk);
      reg_req = '{1'b0, 1'b1, a, ~d};
      @(negedge sys_clk);
      ok = reg_rvalid;
      q = reg_rdata;
      reg_req = '{1'b0, 1'b0, ~a, ~d};
   endtask
endmodule

// File: verilog/ulm_led_map.sv
// User LED mapping register bank with button status.
// Assumes the serial interface engine presents decoded register accesses
// and that indicator levels and status updates come from same-clock logic.
`timescale 1ns/100ps
module ulm_led_map
   import ulm_pkg::*;
(
   input  wire logic                           sys_clk,
   input  wire logic                           resetn,
   input  wire ulm_reg_req_t                   reg_req,
   output logic      [7:0]                     reg_rdata,
   output logic                                reg_rvalid,
   input  wire ulm_led_cmd_t                   led_cmd,
   input  wire logic [7:0]                     sys_indicators,
   input  wire logic                           status_update,
   input  wire logic [ULM_NUM_BUTTONS-1:0]     button_pin,
   output logic      [ULM_NUM_LEDS-1:0]        user_led_on,
   output logic      [ULM_NUM_USER_BUTTONS-1:0] user_button_state,
   output logic      [ULM_NUM_BUTTONS-1:ULM_NUM_USER_BUTTONS] sys_button_state
);
   logic [7:0]                 map_reg  [ULM_NUM_LEDS];
   logic [7:0]                 map_next [ULM_NUM_LEDS];
   logic [ULM_NUM_LEDS-1:0]    led_reg;
   logic [ULM_NUM_LEDS-1:0]    led_next;
   logic [7:0]                 rdata_reg;
   logic [7:0]                 rdata_next;
   logic                       rvalid_reg;
   logic                       rvalid_next;
   logic [ULM_NUM_BUTTONS-1:0] btn_sync;
   logic [ULM_NUM_BUTTONS-1:0] btn_reg;
   logic [ULM_NUM_BUTTONS-1:0] btn_next;
   logic [7:0]                 map_ofs  [ULM_NUM_LEDS];

   assign map_ofs[ULM_LED_GREEN] = ULM_GREEN_MAP_OFS;
   assign map_ofs[ULM_LED_BLUE]  = ULM_BLUE_MAP_OFS;

   ulm_sync #(
      .WIDTH (ULM_NUM_BUTTONS)
   ) u_sync (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .pin_in   (button_pin),
      .sync_out (btn_sync)
   );

   // Mapping bytes and LED state, one pass per user LED
   always_comb
   begin
      for (int i = 0; i < ULM_NUM_LEDS; i++)
      begin
         map_next[i] = map_reg[i];
         if (reg_req.wr && reg_req.addr == map_ofs[i])
         begin
            map_next[i] = reg_req.wdata;
         end
         led_next[i] = led_reg[i];
         if (led_cmd.wr[i])
         begin
            led_next[i] = led_cmd.on[i];
         end
         // Status update wins over a same-cycle command, as it comes later in
         // the system's refresh; an empty map never touches the LED.
         if (status_update && map_reg[i] != '0)
         begin
            led_next[i] = |(map_reg[i] & sys_indicators);
         end
      end
   end

   // Register reads answer one cycle later; unmapped offsets read zero
   always_comb
   begin
      rvalid_next = reg_req.rd;
      rdata_next  = ULM_READ_UNMAPPED;
      if (reg_req.rd)
      begin
         case (reg_req.addr)
            ULM_GREEN_MAP_OFS: rdata_next = map_reg[ULM_LED_GREEN];
            ULM_BLUE_MAP_OFS:  rdata_next = map_reg[ULM_LED_BLUE];
            default:           rdata_next = ULM_READ_UNMAPPED;
         endcase
      end
      btn_next = btn_sync;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < ULM_NUM_LEDS; i++)
         begin
            map_reg[i] <= ULM_MAP_RESET;
         end
         led_reg    <= '0;
         rdata_reg  <= '0;
         rvalid_reg <= 1'b0;
         btn_reg    <= '0;
      end
      else
      begin
         for (int i = 0; i < ULM_NUM_LEDS; i++)
         begin
            map_reg[i] <= map_next[i];
         end
         led_reg    <= led_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
         btn_reg    <= btn_next;
      end
   end

   assign user_led_on       = led_reg;
   assign reg_rdata         = rdata_reg;
   assign reg_rvalid        = rvalid_reg;
   assign user_button_state = btn_reg[ULM_NUM_USER_BUTTONS-1:0];
   assign sys_button_state  = btn_reg[ULM_NUM_BUTTONS-1:ULM_NUM_USER_BUTTONS];

   // Checking logic
   logic [1:0] warm_cnt;
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         warm_cnt <= 2'd0;
      end
      else if (warm_cnt != 2'd3)
      begin
         warm_cnt <= warm_cnt + 2'd1;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence green_wr_s;
      reg_req.wr && reg_req.addr == ULM_GREEN_MAP_OFS;
   endsequence

   sequence blue_rd_s;
      reg_req.rd && reg_req.addr == ULM_BLUE_MAP_OFS && !reg_req.wr;
   endsequence

   green_write_a: assert property (green_wr_s ##1 reg_req.rd && !reg_req.wr
         && reg_req.addr == ULM_GREEN_MAP_OFS |=> reg_rvalid
         && reg_rdata == $past(reg_req.wdata, 2))
      else $error("green mapping byte did not read back");

   bit_select_a: assert property (status_update && map_reg[ULM_LED_GREEN] == 8'h04
         |=> user_led_on[ULM_LED_GREEN] == $past(sys_indicators[ULM_BIT_CHARGING]))
      else $error("green LED not following selected indicator");

   blue_read_a: assert property (blue_rd_s |=> reg_rvalid
         && reg_rdata == $past(map_reg[ULM_LED_BLUE]))
      else $error("blue mapping byte read wrong");

   cmd_obeyed_a: assert property (led_cmd.wr[ULM_LED_BLUE] && !status_update
         |=> user_led_on[ULM_LED_BLUE] == $past(led_cmd.on[ULM_LED_BLUE]))
      else $error("blue LED ignored host command");

   shared_led_a: assert property (status_update && map_reg[ULM_LED_BLUE] != 8'h00
         |=> user_led_on[ULM_LED_BLUE]
             == $past(|(map_reg[ULM_LED_BLUE] & sys_indicators)))
      else $error("blue LED not the OR of mapped indicators");

   button_follow_a: assert property (warm_cnt == 2'd3 ##0 $stable(button_pin) [*3]
         |-> user_button_state == button_pin[ULM_NUM_USER_BUTTONS-1:0])
      else $error("user button state lags the pins");

   empty_map_a: assert property (status_update && map_reg[ULM_LED_GREEN] == 8'h00
         && !led_cmd.wr[ULM_LED_GREEN] |=> $stable(user_led_on[ULM_LED_GREEN]))
      else $error("unmapped green LED changed on status update");
endmodule

// File: verilog/ulm_sync.sv
// Two-stage synchroniser bank for the push-button pins.
// Assumes raw asynchronous pins; only stage two is read downstream.
`timescale 1ns/100ps
module ulm_sync
   import ulm_pkg::*;
#(
   parameter int WIDTH = ULM_NUM_BUTTONS
)
(
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_comb
         begin
            meta_next[i] = pin_in[i];
            sync_next[i] = meta_reg[i];
         end
      end
   endgenerate

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule
